/* cld_core.sv */
// Load-instruction fetch, decode and execute engine with its memory cycle sequencer
// What this block does
// - ED then 47 copies the accumulator into the interrupt-vector register, no flags, cycles of 4 and 5 T.
// - ED then 5F copies the refresh register into the accumulator, sign from bit 7, subtract cleared, carry kept.
// - On that load parity/overflow takes interrupt_enable_copy, forced to zero if an interrupt is accepted meanwhile.
// - ED then 4F copies the accumulator into the refresh register, no flags, 9 T-states.
// - 00 rrr 110 reads one immediate byte into the selected register in cycles of 4 and 3 T.
// - 32 plus a 16-bit address stores the accumulator there in cycles of 4, 3, 3, 3 T.
// - 36 plus a byte writes it at pointer_pair in 4,3,3 T; the indexed form with displacement takes 4,4,3,5,3 T.
// - 01 rrr 110 loads a register from pointer_pair in 4,3 T; the indexed form takes 4,4,3,5,3 T.
// - Bit 5 of the index prefix picks first_index_register at 0 and second_index_register at 1.
// - 0A and 1A load the accumulator through the first and second general pairs in 4,3 T.
// - 3A plus low then high address byte loads the accumulator in 13 T-states.
// - A 16-bit immediate pair load takes the low byte first, then the high byte, in 4,3,3 T.
// - Index prefix plus 21 plus low and high bytes loads the selected index register in 4,4,3,3 T.
// - F9 copies pointer_pair into the stack pointer in 6 T; prefixed it copies an index register in 4 and 6 T.
// - The 3-bit field names B,C,D,E,H,L,-,A from 000 to 111, with 110 meaning memory.
`timescale 1ns/1ps
module cld_core
  import cld_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  output logic      [15:0] MEM_ADDR,
  output logic             MEM_RD,
  output logic             MEM_WR,
  output logic             MEM_M1,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        INT_ENABLE_COPY,
  input  wire logic        INT_ACCEPT,
  output logic             INSTR_DONE,
  output logic      [63:0] REG_BANK,
  output logic      [7:0]  REG_F,
  output logic      [7:0]  REG_I,
  output logic      [7:0]  REG_R,
  output logic      [15:0] REG_SP,
  output logic      [15:0] REG_IDX0,
  output logic      [15:0] REG_IDX1,
  output logic      [15:0] REG_PC
);
  cld_state_t      state_reg;
  cld_state_t      state_next;
  cld_pfx_t        pfx_reg;
  cld_asrc_t       asrc_reg;
  cld_class_t      cls_w;
  cld_state_t      plan_st;
  cld_asrc_t       plan_as;
  logic [2:0]      plan_len;
  logic [2:0]      tcnt_reg;
  logic [2:0]      len_reg;
  logic [1:0]      step_reg;
  logic [7:0]      op_reg;
  logic [7:0]      lo_reg;
  logic [7:0]      f_reg;
  logic [7:0]      i_reg;
  logic [7:0]      r_reg;
  logic [15:0]     sp_reg;
  logic [15:0]     ix0_reg;
  logic [15:0]     ix1_reg;
  logic [15:0]     pc_reg;
  logic            int_seen_reg;
  logic [7:0][7:0] regs_w;

  logic        idx_w;
  logic [15:0] ixy_w;
  logic [15:0] hl_w;
  logic [15:0] pair_w;
  logic [15:0] ea_w;
  logic [2:0]  m1_len_w;
  logic [2:0]  tlen_w;
  logic        end_w;
  logic [1:0]  pidx_w;
  logic        fin_w;
  logic        exec_w;
  logic        pc_inc_w;
  logic [15:0] pc_next;
  logic [15:0] addr_next;
  logic [7:0]  wdata_next;
  logic [7:0]  acc_w;
  logic [7:0]  ir_src_w;
  logic        pv_w;
  logic [7:0]  f_next;
  logic        wr8_en_w;
  logic [2:0]  wr8_sel_w;
  logic [7:0]  wr8_data_w;
  logic        wr16_en_w;
  logic [15:0] word_w;

  // Decode of the opcode in hand under the current prefix
  assign idx_w = pfx_reg[1];
  assign ixy_w = pfx_reg[0] ? ix1_reg : ix0_reg;
  assign hl_w  = {regs_w[RF_HIGH], regs_w[RF_LOW]};
  assign acc_w = regs_w[RF_ACC];
  assign pair_w = op_reg[4] ? {regs_w[2], regs_w[3]} : {regs_w[0], regs_w[1]};
  assign ea_w  = idx_w ? (ixy_w + {{8{lo_reg[7]}}, lo_reg}) : hl_w;

  always_comb begin
    cls_w = CL_NOP;
    if (pfx_reg == PF_ED) begin
      case (op_reg)
        OP_I_A:  cls_w = CL_I_A;
        OP_A_I:  cls_w = CL_A_I;
        OP_R_A:  cls_w = CL_R_A;
        OP_A_R:  cls_w = CL_A_R;
        default: cls_w = CL_NOP;
      endcase
    end else if (op_reg == OP_PFX_ED || op_reg == OP_PFX_I0 || op_reg == OP_PFX_I1)
      cls_w = CL_PFX;
    else if (op_reg == OP_M_N)
      cls_w = CL_M_N;
    else if (op_reg == OP_HALT)
      cls_w = CL_NOP;
    else if (op_reg[7:6] == 2'b01 && op_reg[2:0] == RF_MEM)
      cls_w = CL_R_M;
    else if (op_reg[7:3] == 5'b01110)
      cls_w = CL_M_R;
    else if (op_reg[7:6] == 2'b00 && op_reg[2:0] == RF_MEM)
      cls_w = CL_R_N;
    else if (op_reg == OP_A_BC || op_reg == OP_A_DE)
      cls_w = CL_A_PR;
    else if (op_reg == OP_NN_A)
      cls_w = CL_NN_A;
    else if (op_reg == OP_A_NN)
      cls_w = CL_A_NN;
    else if (idx_w && op_reg == OP_IDX_NN)
      cls_w = CL_IDX_NN;
    else if (op_reg[7:6] == 2'b00 && op_reg[3:0] == 4'b0001)
      cls_w = CL_RP_NN;
    else if (op_reg == OP_SP)
      cls_w = CL_SP;
  end

  // Opcode-fetch length: ED transfers stretch to 5 T, stack-pointer copy to 6 T
  assign m1_len_w = (cls_w == CL_SP) ? T_M1_SP :
                    (cls_w == CL_I_A || cls_w == CL_A_I || cls_w == CL_R_A || cls_w == CL_A_R) ? T_M1_LONG :
                    T_M1;
  assign tlen_w = (state_reg == ST_M1) ? m1_len_w : len_reg;
  assign end_w  = (tcnt_reg == tlen_w - 3'h1);
  assign pidx_w = (state_reg == ST_M1) ? 2'h0 : step_reg + 2'h1;

  // Machine cycle that follows; ST_M1 here means the instruction is complete
  always_comb begin
    plan_st  = ST_M1;
    plan_as  = AS_PC;
    plan_len = T_MEM;
    case (cls_w)
      CL_R_N, CL_A_PR: begin
        if (pidx_w == 2'h0) plan_st = ST_RD;
        if (cls_w == CL_A_PR) plan_as = AS_PAIR;
      end
      CL_M_N: begin
        if (pidx_w == 2'h0) plan_st = ST_RD;
        else if (pidx_w == 2'h1 && !idx_w) begin
          plan_st = ST_WR;
          plan_as = AS_EA;
        end else if (pidx_w == 2'h1) begin
          plan_st  = ST_RD;
          plan_len = T_EXT;
        end else if (pidx_w == 2'h2 && idx_w) begin
          plan_st = ST_WR;
          plan_as = AS_EA;
        end
      end
      CL_R_M, CL_M_R: begin
        if (!idx_w && pidx_w == 2'h0) begin
          plan_st = (cls_w == CL_R_M) ? ST_RD : ST_WR;
          plan_as = AS_EA;
        end else if (idx_w && pidx_w == 2'h0)
          plan_st = ST_RD;
        else if (idx_w && pidx_w == 2'h1) begin
          plan_st  = ST_INT;
          plan_len = T_EXT;
        end else if (idx_w && pidx_w == 2'h2) begin
          plan_st = (cls_w == CL_R_M) ? ST_RD : ST_WR;
          plan_as = AS_EA;
        end
      end
      CL_NN_A, CL_A_NN: begin
        if (pidx_w != 2'h2 && pidx_w != 2'h3) plan_st = ST_RD;
        else if (pidx_w == 2'h2) begin
          plan_st = (cls_w == CL_A_NN) ? ST_RD : ST_WR;
          plan_as = AS_DIR;
        end
      end
      CL_RP_NN, CL_IDX_NN: begin
        if (pidx_w == 2'h0 || pidx_w == 2'h1) plan_st = ST_RD;
      end
      default: plan_st = ST_M1;
    endcase
  end

  assign fin_w      = end_w && (plan_st == ST_M1);
  assign exec_w     = fin_w && (state_reg != ST_M1 || cls_w != CL_PFX);
  assign state_next = end_w ? plan_st : state_reg;
  assign pc_inc_w   = end_w && (state_reg == ST_M1 || (state_reg == ST_RD && asrc_reg == AS_PC));
  assign pc_next    = pc_reg + {15'h0000, pc_inc_w};
  // High address byte arrives in the same edge that starts the direct access
  assign addr_next  = (plan_st == ST_M1 || plan_as == AS_PC) ? pc_next :
                      (plan_as == AS_EA) ? ea_w :
                      (plan_as == AS_PAIR) ? pair_w : {MEM_RDATA, lo_reg};
  assign wdata_next = (cls_w == CL_NN_A) ? acc_w :
                      (cls_w == CL_M_R) ? regs_w[op_reg[2:0]] : MEM_RDATA;
  assign word_w     = {MEM_RDATA, lo_reg};

  // Accumulator transfer flags; an accepted interrupt masks the enable copy
  assign ir_src_w = (cls_w == CL_A_R) ? r_reg : i_reg;
  assign pv_w     = INT_ENABLE_COPY && !int_seen_reg && !INT_ACCEPT;
  always_comb begin
    f_next        = f_reg;
    f_next[FL_S]  = ir_src_w[7];
    f_next[FL_Z]  = (ir_src_w == RST_BYTE);
    f_next[FL_H]  = 1'b0;
    f_next[FL_PV] = pv_w;
    f_next[FL_N]  = 1'b0;
  end

  assign wr8_en_w   = exec_w && (cls_w == CL_R_N || cls_w == CL_R_M || cls_w == CL_A_PR ||
                                 cls_w == CL_A_NN || cls_w == CL_A_I || cls_w == CL_A_R);
  assign wr8_sel_w  = (cls_w == CL_R_N || cls_w == CL_R_M) ? op_reg[5:3] : RF_ACC;
  assign wr8_data_w = (cls_w == CL_A_I || cls_w == CL_A_R) ? ir_src_w : MEM_RDATA;
  assign wr16_en_w  = exec_w && (cls_w == CL_RP_NN) && (op_reg[5:4] != PR_SP);

  cld_regfile u_regs (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .wr8_en    (wr8_en_w),
    .wr8_sel   (wr8_sel_w),
    .wr8_data  (wr8_data_w),
    .wr16_en   (wr16_en_w),
    .wr16_sel  (op_reg[5:4]),
    .wr16_data (word_w),
    .regs_q    (regs_w)
  );

  // Cycle sequencing
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg <= ST_M1;
      tcnt_reg  <= 3'h0;
      len_reg   <= T_MEM;
      step_reg  <= 2'h0;
      asrc_reg  <= AS_PC;
      MEM_ADDR  <= RST_WORD;
      MEM_WDATA <= RST_BYTE;
      pc_reg    <= RST_WORD;
    end else begin
      state_reg <= state_next;
      tcnt_reg  <= end_w ? 3'h0 : tcnt_reg + 3'h1;
      if (end_w) begin
        len_reg   <= plan_len;
        step_reg  <= pidx_w;
        asrc_reg  <= plan_as;
        MEM_ADDR  <= addr_next;
        MEM_WDATA <= wdata_next;
      end
      pc_reg <= pc_next;
    end
  end

  // Opcode, prefix and operand capture
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      op_reg  <= RST_BYTE;
      pfx_reg <= PF_NONE;
      lo_reg  <= RST_BYTE;
    end else begin
      if (state_reg == ST_M1 && tcnt_reg == T_SAMPLE)
        op_reg <= MEM_RDATA;
      if (end_w && state_reg == ST_RD && step_reg == 2'h0)
        lo_reg <= MEM_RDATA;
      if (fin_w && state_reg == ST_M1 && cls_w == CL_PFX)
        pfx_reg <= (op_reg == OP_PFX_ED) ? PF_ED : cld_pfx_t'({1'b1, op_reg[PFX_SEL_BIT]});
      else if (fin_w)
        pfx_reg <= PF_NONE;
    end
  end

  // Special and 16-bit registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      f_reg        <= RST_BYTE;
      i_reg        <= RST_BYTE;
      r_reg        <= RST_BYTE;
      sp_reg       <= RST_WORD;
      ix0_reg      <= RST_WORD;
      ix1_reg      <= RST_WORD;
      int_seen_reg <= 1'b0;
    end else begin
      // Spans prefix bytes; final-cycle accepts are seen directly, so the end clears
      int_seen_reg <= exec_w ? 1'b0 : (int_seen_reg || INT_ACCEPT);
      if (exec_w && (cls_w == CL_A_I || cls_w == CL_A_R))
        f_reg <= f_next;
      if (exec_w && cls_w == CL_I_A)
        i_reg <= acc_w;
      if (exec_w && cls_w == CL_R_A)
        r_reg <= acc_w;
      if (exec_w && cls_w == CL_RP_NN && op_reg[5:4] == PR_SP)
        sp_reg <= word_w;
      else if (exec_w && cls_w == CL_SP)
        sp_reg <= idx_w ? ixy_w : hl_w;
      if (exec_w && cls_w == CL_IDX_NN && !pfx_reg[0])
        ix0_reg <= word_w;
      if (exec_w && cls_w == CL_IDX_NN && pfx_reg[0])
        ix1_reg <= word_w;
    end
  end

  assign MEM_M1     = (state_reg == ST_M1);
  assign MEM_RD     = (state_reg == ST_RD) || (MEM_M1 && tcnt_reg <= T_SAMPLE);
  assign MEM_WR     = (state_reg == ST_WR);
  assign INSTR_DONE = exec_w;
  assign REG_BANK   = regs_w;
  assign REG_F      = f_reg;
  assign REG_I      = i_reg;
  assign REG_R      = r_reg;
  assign REG_SP     = sp_reg;
  assign REG_IDX0   = ix0_reg;
  assign REG_IDX1   = ix1_reg;
  assign REG_PC     = pc_reg;
endmodule // cld_core

/* cld_regfile.sv */
// Shared constants and the general-purpose 8-bit register bank of the load engine
package cld_pkg;
  // Machine-cycle kinds; ST_M1 doubles as the end marker in the plan table
  typedef enum logic [1:0] {
    ST_M1  = 2'b00,
    ST_RD  = 2'b01,
    ST_WR  = 2'b10,
    ST_INT = 2'b11
  } cld_state_t;

  typedef enum logic [1:0] {
    PF_NONE = 2'b00,
    PF_ED   = 2'b01,
    PF_IDX0 = 2'b10,
    PF_IDX1 = 2'b11
  } cld_pfx_t;

  typedef enum logic [1:0] {
    AS_PC   = 2'b00,
    AS_EA   = 2'b01,
    AS_PAIR = 2'b10,
    AS_DIR  = 2'b11
  } cld_asrc_t;

  typedef enum logic [3:0] {
    CL_NOP     = 4'b0000,
    CL_PFX     = 4'b0001,
    CL_I_A     = 4'b0010,
    CL_A_I     = 4'b0011,
    CL_A_R     = 4'b0100,
    CL_R_A     = 4'b0101,
    CL_R_N     = 4'b0110,
    CL_M_N     = 4'b0111,
    CL_R_M     = 4'b1000,
    CL_M_R     = 4'b1001,
    CL_A_PR    = 4'b1010,
    CL_NN_A    = 4'b1011,
    CL_A_NN    = 4'b1100,
    CL_RP_NN   = 4'b1101,
    CL_IDX_NN  = 4'b1110,
    CL_SP      = 4'b1111
  } cld_class_t;

  // T-state lengths of machine cycles
  localparam logic [2:0] T_M1      = 3'h4;
  localparam logic [2:0] T_M1_LONG = 3'h5;
  localparam logic [2:0] T_M1_SP   = 3'h6;
  localparam logic [2:0] T_MEM     = 3'h3;
  localparam logic [2:0] T_EXT     = 3'h5;
  localparam logic [2:0] T_SAMPLE  = 3'h1;

  // Opcode bytes
  localparam logic [7:0] OP_PFX_ED = 8'hED;
  localparam logic [7:0] OP_PFX_I0 = 8'hDD;
  localparam logic [7:0] OP_PFX_I1 = 8'hFD;
  localparam logic [7:0] OP_I_A    = 8'h47;
  localparam logic [7:0] OP_A_I    = 8'h57;
  localparam logic [7:0] OP_R_A    = 8'h4F;
  localparam logic [7:0] OP_A_R    = 8'h5F;
  localparam logic [7:0] OP_M_N    = 8'h36;
  localparam logic [7:0] OP_HALT   = 8'h76;
  localparam logic [7:0] OP_A_BC   = 8'h0A;
  localparam logic [7:0] OP_A_DE   = 8'h1A;
  localparam logic [7:0] OP_NN_A   = 8'h32;
  localparam logic [7:0] OP_A_NN   = 8'h3A;
  localparam logic [7:0] OP_IDX_NN = 8'h21;
  localparam logic [7:0] OP_SP     = 8'hF9;
  localparam logic [2:0] PFX_SEL_BIT = 3'h5;

  // Register field codes and pair codes
  localparam logic [2:0] RF_MEM  = 3'h6;
  localparam logic [2:0] RF_ACC  = 3'h7;
  localparam logic [2:0] RF_HIGH = 3'h4;
  localparam logic [2:0] RF_LOW  = 3'h5;
  localparam logic [1:0] PR_SP   = 2'h3;

  // Flag bit positions
  localparam int FL_S  = 7;
  localparam int FL_Z  = 6;
  localparam int FL_H  = 4;
  localparam int FL_PV = 2;
  localparam int FL_N  = 1;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage : cld_pkg

`timescale 1ns/1ps
module cld_regfile
  import cld_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            wr8_en,
  input  wire logic [2:0]      wr8_sel,
  input  wire logic [7:0]      wr8_data,
  input  wire logic            wr16_en,
  input  wire logic [1:0]      wr16_sel,
  input  wire logic [15:0]     wr16_data,
  output logic      [7:0][7:0] regs_q
);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ent
      if (g == 6) begin : g_mem
        // Code 110 names a memory operand, so no storage here
        assign regs_q[g] = RST_BYTE;
      end else begin : g_reg
        logic       hit8_w;
        logic       hit16_w;
        logic [7:0] ent_reg;
        assign hit8_w    = wr8_en && (wr8_sel == 3'(g));
        assign hit16_w   = wr16_en && (g < 6) && (wr16_sel == 2'(g / 2));
        // Own storage per entry keeps one process per variable
        assign regs_q[g] = ent_reg;
        always_ff @(posedge clk) begin
          if (!rst_n)
            ent_reg <= RST_BYTE;
          else if (hit8_w)
            ent_reg <= wr8_data;
          else if (hit16_w)
            ent_reg <= (g % 2 == 0) ? wr16_data[15:8] : wr16_data[7:0];
        end
      end
    end
  endgenerate
endmodule // cld_regfile

/* cld_core_props.sv */
// Port-level assertions of the load engine, bound onto its top module
`timescale 1ns/1ps
module cld_core_props
  import cld_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic [15:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic        MEM_M1,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic        INT_ACCEPT,
  input wire logic        INSTR_DONE,
  input wire logic [63:0] REG_BANK,
  input wire logic [7:0]  REG_F,
  input wire logic [7:0]  REG_I,
  input wire logic [7:0]  REG_R,
  input wire logic [15:0] REG_IDX0,
  input wire logic [15:0] REG_IDX1
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_fetch_head;
    (MEM_M1 && MEM_RD) [*2] ##1 (MEM_M1 && !MEM_RD && !MEM_WR);
  endsequence
  sequence s_write_body;
    (MEM_WR && $stable(MEM_ADDR) && $stable(MEM_WDATA)) [*2];
  endsequence

  property p_fetch_follows;
    INSTR_DONE |=> s_fetch_head;
  endproperty
  a_fetch_follows: assert property (p_fetch_follows) else $error("no opcode fetch after instruction end");
  property p_write_cycle;
    $rose(MEM_WR) |=> s_write_body ##0 INSTR_DONE ##1 !MEM_WR;
  endproperty
  a_write_cycle: assert property (p_write_cycle) else $error("write cycle length or hold wrong");
  property p_vector_load;
    !$stable(REG_I) |-> $past(INSTR_DONE) && $stable(REG_F);
  endproperty
  a_vector_load: assert property (p_vector_load) else $error("vector register changed out of turn");
  property p_refresh_load;
    !$stable(REG_R) |-> $past(INSTR_DONE) && $stable(REG_F);
  endproperty
  a_refresh_load: assert property (p_refresh_load) else $error("refresh register changed out of turn");
  property p_flag_update;
    !$stable(REG_F) |-> $past(INSTR_DONE) && !REG_F[FL_N] && !REG_F[FL_H] && REG_F[FL_S] == REG_BANK[63];
  endproperty
  a_flag_update: assert property (p_flag_update) else $error("flags wrong after accumulator load");
  property p_accept_clears;
    INT_ACCEPT && INSTR_DONE |=> $stable(REG_F) || !REG_F[FL_PV];
  endproperty
  a_accept_clears: assert property (p_accept_clears) else $error("parity flag set despite accepted interrupt");
  property p_mem_code_empty;
    REG_BANK[55:48] == 8'h00;
  endproperty
  a_mem_code_empty: assert property (p_mem_code_empty) else $error("memory code slot holds data");
  property p_index_load;
    !$stable({REG_IDX0, REG_IDX1}) |-> $past(INSTR_DONE) && $stable(REG_F);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index register changed out of turn");
  property p_strobe_excl;
    !(MEM_RD && MEM_WR);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
endmodule // cld_core_props

bind cld_core cld_core_props i_cld_core_props (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
  .MEM_M1(MEM_M1), .MEM_WDATA(MEM_WDATA), .INT_ACCEPT(INT_ACCEPT), .INSTR_DONE(INSTR_DONE),
  .REG_BANK(REG_BANK), .REG_F(REG_F), .REG_I(REG_I), .REG_R(REG_R), .REG_IDX0(REG_IDX0),
  .REG_IDX1(REG_IDX1)
);

/* cld_mem_model.sv */
// Zero-wait program and data memory on the processor bus
`timescale 1ns/1ps
module cld_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;

  // Released bus shows the inverted last byte, so a late sample cannot match
  assign rdata = rd ? mem[addr] : ~last_reg;

  initial begin
    last_reg = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  always @(posedge clk) begin
    if (rd) last_reg <= mem[addr];
    if (wr) mem[addr] <= wdata;
  end
endmodule // cld_mem_model

/* cpu_load_instruction_decode_bench.sv */
// Self-checking bench of the load engine running programs from the memory model
`timescale 1ns/1ps
module cpu_load_instruction_decode_bench;
  import cld_pkg::*;
  logic        clk_sys, rst_n, mem_rd, mem_wr, mem_m1, int_enable_copy, int_accept, instr_done;
  logic [15:0] mem_addr, reg_sp, reg_idx0, reg_idx1, reg_pc, pc;
  logic [7:0]  mem_wdata, mem_rdata, reg_f, reg_i, reg_r;
  logic [63:0] reg_bank;
  logic [7:0]  init_val [0:7] = '{8'h10, 8'h01, 8'h20, 8'h02, 8'h30, 8'h03, 8'h00, 8'hA5};
  int          n_mismatch, total_checks, cycles, cyc_count;

  cld_core i_cld_core (.CLK_SYS(clk_sys), .RST_N(rst_n), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
    .MEM_M1(mem_m1), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .INT_ENABLE_COPY(int_enable_copy),
    .INT_ACCEPT(int_accept), .INSTR_DONE(instr_done), .REG_BANK(reg_bank), .REG_F(reg_f), .REG_I(reg_i),
    .REG_R(reg_r), .REG_SP(reg_sp), .REG_IDX0(reg_idx0), .REG_IDX1(reg_idx1), .REG_PC(reg_pc));
  cld_mem_model i_cld_mem_model (.clk(clk_sys), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata),
    .rdata(mem_rdata));

  always #12.5 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Bytes land during the fetch's first clock, ahead of its sampling edge
  task automatic put(input logic [7:0] b);
    i_cld_mem_model.mem[pc] = b;
    pc++;
  endtask

  // Clocks from first fetch cycle to the done cycle, then let the final edge land
  task automatic exec;
    cycles = 0;
    do begin
      @(negedge clk_sys);
      cycles++;
    end while (instr_done !== 1'b1 && cycles < 40);
    if (instr_done !== 1'b1)
      n_mismatch++;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic t_imm8;
    for (int r = 0; r < 8; r++) begin
      if (r != 6) begin
        put({2'b00, 3'(r), 3'b110});
        put(init_val[r]);
        exec();
        check(16'(cycles), 16'h0007);
        check(reg_bank[r*8 +: 8], init_val[r]);
      end
    end
  endtask

  task automatic t_special;
    put(OP_PFX_ED); put(OP_I_A); exec();
    check(16'(cycles), 16'h0009);
    check(reg_i, 8'hA5);
    check(reg_f, 8'h00);
    put(OP_PFX_ED); put(OP_R_A); exec();
    check(16'(cycles), 16'h0009);
    check(reg_r, 8'hA5);
    put(8'h3E); put(8'h00); exec();
    int_enable_copy = 1'b1;
    // Accepted interrupt first, so a missing clear leaves parity visibly set
    int_accept = 1'b1;
    put(OP_PFX_ED); put(OP_A_R); exec();
    int_accept = 1'b0;
    check(16'(cycles), 16'h0009);
    check(reg_bank[63:56], 8'hA5);
    check(reg_f, 8'h80);
    put(OP_PFX_ED); put(OP_A_R); exec();
    check(reg_f, 8'h84);
    // One-cycle accept during the prefix fetch only
    put(OP_PFX_ED); put(OP_A_R);
    @(posedge clk_sys);
    #1 int_accept = 1'b1;
    @(posedge clk_sys);
    #1 int_accept = 1'b0;
    exec();
    check(reg_f, 8'h80);
    put(8'h3E); put(8'h00); exec();
    int_enable_copy = 1'b0;
    put(OP_PFX_ED); put(OP_A_I); exec();
    check(16'(cycles), 16'h0009);
    check(reg_bank[63:56], 8'hA5);
    check(reg_f, 8'h80);
  endtask

  task automatic t_memory;
    i_cld_mem_model.mem[16'h1001] = 8'h5A;
    i_cld_mem_model.mem[16'h2002] = 8'h3C;
    i_cld_mem_model.mem[16'h1234] = 8'hC3;
    put(OP_A_DE); exec();
    check(16'(cycles), 16'h0007);
    check(reg_bank[63:56], 8'h3C);
    put(OP_A_BC); exec();
    check(reg_bank[63:56], 8'h5A);
    put(OP_NN_A); put(8'h00); put(8'h40); exec();
    check(16'(cycles), 16'h000D);
    check(i_cld_mem_model.mem[16'h4000], 8'h5A);
    put(OP_A_NN); put(8'h34); put(8'h12); exec();
    check(16'(cycles), 16'h000D);
    check(reg_bank[63:56], 8'hC3);
    put(OP_M_N); put(8'h77); exec();
    check(16'(cycles), 16'h000A);
    check(i_cld_mem_model.mem[16'h3003], 8'h77);
    put(8'h7E); exec();
    check(16'(cycles), 16'h0007);
    check(reg_bank[63:56], 8'h77);
    put(8'h70); exec();
    check(i_cld_mem_model.mem[16'h3003], 8'h10);
  endtask

  task automatic t_index;
    i_cld_mem_model.mem[16'h1236] = 8'hE7;
    put(OP_PFX_I0); put(OP_IDX_NN); put(8'h34); put(8'h12); exec();
    check(16'(cycles), 16'h000E);
    check(reg_idx0, 16'h1234);
    put(OP_PFX_I1); put(OP_IDX_NN); put(8'h78); put(8'h56); exec();
    check(reg_idx1, 16'h5678);
    put(OP_PFX_I1); put(OP_M_N); put(8'hFE); put(8'h99); exec();
    check(16'(cycles), 16'h0013);
    check(i_cld_mem_model.mem[16'h5676], 8'h99);
    put(OP_PFX_I0); put(8'h46); put(8'h02); exec();
    check(16'(cycles), 16'h0013);
    check(reg_bank[7:0], 8'hE7);
    put(OP_PFX_I1); put(8'h71); put(8'hFE); exec();
    check(16'(cycles), 16'h0013);
    check(i_cld_mem_model.mem[16'h5676], 8'h01);
  endtask

  task automatic t_pairs;
    for (int p = 0; p < 4; p++) begin
      put({2'b00, 2'(p), 4'b0001}); put(8'(8'hC0 + p)); put(8'(8'h40 + p)); exec();
      check(16'(cycles), 16'h000A);
      check(p == 3 ? reg_sp : {reg_bank[p*16 +: 8], reg_bank[p*16+8 +: 8]}, 16'(16'h40C0 + p*16'h0101));
    end
    put(OP_SP); exec();
    check(16'(cycles), 16'h0006);
    check(reg_sp, 16'h42C2);
    put(OP_PFX_I0); put(OP_SP); exec();
    check(16'(cycles), 16'h000A);
    check(reg_sp, 16'h1234);
    check(reg_pc, pc);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    int_enable_copy = 1'b0;
    int_accept = 1'b0;
    pc = 16'h_0000;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    exec();
    pc = 16'h_0001;
    t_imm8();
    t_special();
    t_memory();
    t_index();
    t_pairs();
    report_and_stop();
  end
endmodule // cpu_load_instruction_decode_bench
